//--- include/fefi_pkg.sv
// shared constants and carriers of the flash fault/interrupt config block
package fefi_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_FLASH_CONFIG = 8'h00;
  localparam logic [7:0] OFS_FAULT_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FLASH_STATUS = 8'h08;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h14;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h18;

  // flash_config fields
  localparam int CFG_CMD_DONE_IRQ_EN = 7;
  localparam int CFG_IGNORE_SINGLE = 4;
  localparam int CFG_FORCE_DOUBLE = 1;
  localparam int CFG_FORCE_SINGLE = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h93;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // fault_irq_enable fields
  localparam int FIE_DOUBLE = 1;
  localparam int FIE_SINGLE = 0;
  localparam logic [7:0] FIE_WRITE_MASK = 8'h03;
  localparam logic [7:0] FIE_RESET = 8'h00;

  // flash_status_reg fields
  localparam int FST_CMD_DONE = 7;
  localparam int FST_BUSY = 3;
  localparam logic CMD_DONE_RESET = 1'b1;

  // fault_status_reg fields
  localparam int FLT_DOUBLE = 1;
  localparam int FLT_SINGLE = 0;
  localparam logic [1:0] FLT_RESET = 2'h0;

  // event status layout
  localparam int EVT_WIDTH = 3;
  localparam int EVT_SINGLE = 0;
  localparam int EVT_DOUBLE = 1;
  localparam int EVT_CMD_DONE = 2;
  localparam logic [2:0] EVT_RESET = 3'h0;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // register access as seen by the register file
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } fefi_reg_req_t;

  // flash-side events of one cycle
  typedef struct packed {
    logic array_read;
    logic ecc_single;
    logic ecc_double;
    logic cmd_finish;
    logic cmd_violation;
  } fefi_flash_evt_t;

endpackage

//--- src/fefi_ahb_slave.sv
`timescale 1ns/1ps
// ahb-lite slave front end: zero wait states, reads answered from
// the address phase, writes applied in the data phase
module fefi_ahb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  // register file side
  output fefi_pkg::fefi_reg_req_t req,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data
);

  logic take;
  logic wr_pend;
  logic [7:0] wr_addr;

  // htrans[1] takes nonseq and seq alike, single transfers only
  assign take = hsel & hready & htrans[1];
  assign rd_addr = haddr[7:0];

  // remember a write address phase for its data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // read data sampled at the address phase edge
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= rd_data;
    end
  end

  // write request is valid for the single data phase cycle
  assign req.wr = wr_pend;
  assign req.addr = wr_addr;
  assign req.wdata = hwdata;

endmodule // fefi_ahb_slave

//--- src/fefi_irq_latch.sv
`timescale 1ns/1ps
// sticky event bits with enable mask and one level interrupt
module fefi_irq_latch #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // events and software control
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  input wire logic [WIDTH-1:0] en,
  // state and interrupt
  output logic [WIDTH-1:0] status,
  output logic irq
);

  // one sticky bit per event, set beats a same-cycle clear
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        status[i] <= 1'b0;
      end else if (set[i]) begin
        status[i] <= 1'b1;
      end else if (clr[i]) begin
        status[i] <= 1'b0;
      end
    end
  end

  // level output while any enabled bit stands
  assign irq = |(status & en);

endmodule // fefi_irq_latch

//--- src/fefi_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - with cmd_done_irq_en set, a set command-done flag requests an interrupt.
// - with ignore_single_fault set, genuine single faults are neither flagged nor raised.
// - while force_double_fault is set, every array read sets the double fault flag.
// - with force_double_fault clear, only a genuine double fault or a read while busy sets that flag.
// - a forced double fault raises an interrupt only when its enable is set.
// - while force_single_fault is set, every array read sets the single fault flag.
// - with force_single_fault clear, only a genuine single fault sets that flag.
// - a forced single fault raises an interrupt only when its enable is set.
// - both force bits hold until software writes zero to them.
// - flash_config keeps bits 7, 4, 1 and 0; other bits read zero, ignore writes.
// - with double_fault_irq_en set, a set double fault flag requests an interrupt.
// - with single_fault_irq_en set, a set single fault flag requests an interrupt.
// - both assigned bits of fault_irq_enable are readable and writable.
// - the double fault flag clears only on a written one; zero leaves it.
// - command-done sets on finish or violation; writing one while it is set launches and holds it low till the end.
// - an array read on a block busy with a command sets the double fault flag.
module fefi_top (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // ahb-lite register bus
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HWDATA_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic [1:0] HRESP_OUT,
  // flash array and sequencer events, same clock
  input wire logic ARRAY_READ_IN,
  input wire logic ECC_SINGLE_IN,
  input wire logic ECC_DOUBLE_IN,
  input wire logic CMD_FINISH_IN,
  input wire logic CMD_VIOLATION_IN,
  // command sequencer control
  output logic CMD_LAUNCH_OUT,
  output logic CMD_BUSY_OUT,
  // interrupt requests
  output logic CMD_DONE_IRQ_OUT,
  output logic DOUBLE_FAULT_IRQ_OUT,
  output logic SINGLE_FAULT_IRQ_OUT,
  output logic IRQ_OUT
);

  // bus side
  fefi_pkg::fefi_reg_req_t req;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;

  // flash side events gathered
  fefi_pkg::fefi_flash_evt_t evt;

  // register state
  logic [7:0] flash_config;
  logic [7:0] fault_irq_enable;
  logic cmd_done_flag;
  logic double_fault_flag;
  logic single_fault_flag;
  logic [fefi_pkg::EVT_WIDTH-1:0] evt_enable;
  logic [fefi_pkg::EVT_WIDTH-1:0] evt_status;

  // decoded writes
  logic wr_cfg;
  logic wr_fie;
  logic wr_fst;
  logic wr_flt;
  logic wr_evt_clr;
  logic wr_evt_en;

  // derived events
  logic launch;
  logic cmd_end;
  logic set_double;
  logic set_single;
  logic clr_double;
  logic clr_single;
  logic [fefi_pkg::EVT_WIDTH-1:0] evt_set;
  logic [fefi_pkg::EVT_WIDTH-1:0] evt_clr;

  // config fields by name, so the fault and interrupt logic reads plainly
  logic cmd_done_irq_en;
  logic ignore_single_fault;
  logic force_double_fault;
  logic force_single_fault;
  logic double_fault_irq_en;
  logic single_fault_irq_en;

  // ahb front end; hsize ignored since only words are carried
  // zero wait states: every answer lands one edge after its address phase
  fefi_ahb_slave u_ahb (
    .clk(CLK_IN),
    .rst(RST_IN),
    .hsel(HSEL_IN),
    .haddr(HADDR_IN),
    .htrans(HTRANS_IN),
    .hwrite(HWRITE_IN),
    .hready(HREADY_IN),
    .hwdata(HWDATA_IN),
    .hrdata(HRDATA_OUT),
    .req(req),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // never stalls, never errors
  // nothing here can be slow or refused, so a fixed okay is honest
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = fefi_pkg::HRESP_OKAY;

  // flash-side inputs come from logic on this clock
  // no synchronisers: these share the controller's own clock domain
  assign evt.array_read = ARRAY_READ_IN;
  assign evt.ecc_single = ECC_SINGLE_IN;
  assign evt.ecc_double = ECC_DOUBLE_IN;
  assign evt.cmd_finish = CMD_FINISH_IN;
  assign evt.cmd_violation = CMD_VIOLATION_IN;

  // write decode, one strobe per register
  // only the low byte is decoded, so the upper address bits alias
  assign wr_cfg = req.wr && (req.addr == fefi_pkg::OFS_FLASH_CONFIG);
  assign wr_fie = req.wr && (req.addr == fefi_pkg::OFS_FAULT_IRQ_ENABLE);
  assign wr_fst = req.wr && (req.addr == fefi_pkg::OFS_FLASH_STATUS);
  assign wr_flt = req.wr && (req.addr == fefi_pkg::OFS_FAULT_STATUS);
  assign wr_evt_clr = req.wr && (req.addr == fefi_pkg::OFS_EVT_CLEAR);
  assign wr_evt_en = req.wr && (req.addr == fefi_pkg::OFS_EVT_ENABLE);

  // configuration register; force bits are plain storage so they
  // only ever drop on a software write of zero
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      flash_config <= fefi_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      flash_config <= req.wdata[7:0] & fefi_pkg::CFG_WRITE_MASK;
    end
  end

  // fault interrupt enables
  // only the two assigned bits hold state; the rest read zero
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      fault_irq_enable <= fefi_pkg::FIE_RESET;
    end else if (wr_fie) begin
      fault_irq_enable <= req.wdata[7:0] & fefi_pkg::FIE_WRITE_MASK;
    end
  end

  // field taps; the stored words keep the masked layout software reads back
  assign cmd_done_irq_en = flash_config[fefi_pkg::CFG_CMD_DONE_IRQ_EN];
  assign ignore_single_fault = flash_config[fefi_pkg::CFG_IGNORE_SINGLE];
  assign force_double_fault = flash_config[fefi_pkg::CFG_FORCE_DOUBLE];
  assign force_single_fault = flash_config[fefi_pkg::CFG_FORCE_SINGLE];
  assign double_fault_irq_en = fault_irq_enable[fefi_pkg::FIE_DOUBLE];
  assign single_fault_irq_en = fault_irq_enable[fefi_pkg::FIE_SINGLE];

  // a launch needs an idle sequencer; a one written mid-command is dropped
  // a violation ends the command just as a finish does
  assign launch = wr_fst && req.wdata[fefi_pkg::FST_CMD_DONE] && cmd_done_flag;
  assign cmd_end = evt.cmd_finish | evt.cmd_violation;

  // command-done flag, completion beats a same-cycle launch
  // resets to one so the block comes up idle and ready to launch
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cmd_done_flag <= fefi_pkg::CMD_DONE_RESET;
    end else if (cmd_end) begin
      cmd_done_flag <= 1'b1;
    end else if (launch) begin
      cmd_done_flag <= 1'b0;
    end
  end

  // launch pulse to the sequencer
  // registered so the sequencer sees a clean single-cycle strobe
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      CMD_LAUNCH_OUT <= 1'b0;
    end else begin
      CMD_LAUNCH_OUT <= launch & ~cmd_end;
    end
  end

  // busy mirrors the running command
  // derived, not stored, so it can never disagree with the flag
  assign CMD_BUSY_OUT = ~cmd_done_flag;

  // double fault source: forced, genuine, or read while busy
  always_comb begin
    set_double = 1'b0;
    if (evt.array_read) begin
      if (force_double_fault) begin
        set_double = 1'b1;
      end else begin
        set_double = evt.ecc_double;
      end
      // busy read wins: the array word is not valid then
      // read during command
      if (!cmd_done_flag) begin
        set_double = 1'b1;
      end
    end
  end

  // single fault source: force wins over the ignore bit
  // ignore masks genuine faults only, so a forced test still reaches software
  always_comb begin
    set_single = 1'b0;
    if (evt.array_read) begin
      if (force_single_fault) begin
        set_single = 1'b1;
      end else begin
        set_single = evt.ecc_single & ~ignore_single_fault;
      end
    end
  end

  // write-one-to-clear strobes
  // a zero in either bit leaves that flag alone
  assign clr_double = wr_flt & req.wdata[fefi_pkg::FLT_DOUBLE];
  assign clr_single = wr_flt & req.wdata[fefi_pkg::FLT_SINGLE];

  // double fault flag, a new fault beats a same-cycle clear
  // set wins so a fault in the clearing cycle is never lost
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      double_fault_flag <= fefi_pkg::FLT_RESET[fefi_pkg::FLT_DOUBLE];
    end else if (set_double) begin
      double_fault_flag <= 1'b1;
    end else if (clr_double) begin
      double_fault_flag <= 1'b0;
    end
  end

  // single fault flag, same clearing scheme
  // write-one-to-clear as well, so one write can clear both flags
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      single_fault_flag <= fefi_pkg::FLT_RESET[fefi_pkg::FLT_SINGLE];
    end else if (set_single) begin
      single_fault_flag <= 1'b1;
    end else if (clr_single) begin
      single_fault_flag <= 1'b0;
    end
  end

  // per-source interrupt levels, dropped as soon as flag or enable drops
  // flag and enable
  assign CMD_DONE_IRQ_OUT = cmd_done_flag & cmd_done_irq_en;
  assign DOUBLE_FAULT_IRQ_OUT = double_fault_flag & double_fault_irq_en;
  assign SINGLE_FAULT_IRQ_OUT = single_fault_flag & single_fault_irq_en;

  // event capture enable register
  // apart from the per-fault enables so the summary line is routed alone
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      evt_enable <= fefi_pkg::EVT_RESET;
    end else if (wr_evt_en) begin
      evt_enable <= req.wdata[fefi_pkg::EVT_WIDTH-1:0];
    end
  end

  // flag setting causes, not flag edges, feed the summary latch
  always_comb begin
    evt_set = fefi_pkg::EVT_RESET;
    evt_set[fefi_pkg::EVT_SINGLE] = set_single;
    evt_set[fefi_pkg::EVT_DOUBLE] = set_double;
    evt_set[fefi_pkg::EVT_CMD_DONE] = cmd_end;
  end

  // clear strobes from the write-only clear register
  // anything but a clear write gives all zeros, so no stray clears
  assign evt_clr = wr_evt_clr ? req.wdata[fefi_pkg::EVT_WIDTH-1:0] : fefi_pkg::EVT_RESET;

  // summary interrupt for a single-line controller
  // limitation: every setting cause counts, even onto a flag already set
  fefi_irq_latch #(
    .WIDTH(fefi_pkg::EVT_WIDTH)
  ) u_irq (
    .clk(CLK_IN),
    .rst(RST_IN),
    .set(evt_set),
    .clr(evt_clr),
    .en(evt_enable),
    .status(evt_status),
    .irq(IRQ_OUT)
  );

  // read mux, unmapped and write-only offsets read zero
  // a read right behind a write sees the old value, since it is
  // answered from the address phase
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      fefi_pkg::OFS_FLASH_CONFIG: begin
        rd_data[7:0] = flash_config;
      end
      fefi_pkg::OFS_FAULT_IRQ_ENABLE: begin
        rd_data[7:0] = fault_irq_enable;
      end
      fefi_pkg::OFS_FLASH_STATUS: begin
        rd_data[fefi_pkg::FST_CMD_DONE] = cmd_done_flag;
        rd_data[fefi_pkg::FST_BUSY] = ~cmd_done_flag;
      end
      fefi_pkg::OFS_FAULT_STATUS: begin
        rd_data[fefi_pkg::FLT_DOUBLE] = double_fault_flag;
        rd_data[fefi_pkg::FLT_SINGLE] = single_fault_flag;
      end
      fefi_pkg::OFS_EVT_STATUS: begin
        rd_data[fefi_pkg::EVT_WIDTH-1:0] = evt_status;
      end
      fefi_pkg::OFS_EVT_ENABLE: begin
        rd_data[fefi_pkg::EVT_WIDTH-1:0] = evt_enable;
      end
      // clear register is write-only and reads as zero
      fefi_pkg::OFS_EVT_CLEAR: begin
        rd_data = 32'h0000_0000;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

endmodule // fefi_top

//--- sim/fefi_properties.sv
`timescale 1ns/1ps
// port-level checker of the flash fault and interrupt config block
module fefi_properties (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // register bus
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HWDATA_IN,
  // flash events
  input wire logic ARRAY_READ_IN,
  input wire logic ECC_SINGLE_IN,
  input wire logic ECC_DOUBLE_IN,
  input wire logic CMD_FINISH_IN,
  // outputs under watch
  input wire logic CMD_LAUNCH_OUT,
  input wire logic CMD_BUSY_OUT,
  input wire logic CMD_DONE_IRQ_OUT,
  input wire logic DOUBLE_FAULT_IRQ_OUT,
  input wire logic SINGLE_FAULT_IRQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] cfg;
  logic [7:0] fie;
  // shadow of both config registers, so checks know the live settings
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      cfg <= fefi_pkg::CFG_RESET;
      fie <= fefi_pkg::FIE_RESET;
    end else begin
      wr_pend <= HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN;
      wr_addr <= HADDR_IN[7:0];
      if (wr_pend && wr_addr == fefi_pkg::OFS_FLASH_CONFIG) begin
        cfg <= HWDATA_IN[7:0] & fefi_pkg::CFG_WRITE_MASK;
      end
      if (wr_pend && wr_addr == fefi_pkg::OFS_FAULT_IRQ_ENABLE) begin
        fie <= HWDATA_IN[7:0] & fefi_pkg::FIE_WRITE_MASK;
      end
    end
  end
  // a read with a forced fault and its enable set, no write landing
  sequence s_forced_read(f, e);
    ARRAY_READ_IN && f && e && !wr_pend;
  endsequence
  // launch pulse stands one cycle while the command runs
  sequence s_launch;
    CMD_BUSY_OUT ##1 !CMD_LAUNCH_OUT;
  endsequence
  property p_force_dbl;
    s_forced_read(cfg[1], fie[1]) |=> DOUBLE_FAULT_IRQ_OUT;
  endproperty
  property p_force_sgl;
    s_forced_read(cfg[0], fie[0]) |=> SINGLE_FAULT_IRQ_OUT;
  endproperty
  property p_dbl_cause;
    $rose(DOUBLE_FAULT_IRQ_OUT) && $stable(fie)
      |-> $past(ARRAY_READ_IN && (ECC_DOUBLE_IN || cfg[1] || CMD_BUSY_OUT));
  endproperty
  property p_sgl_cause;
    $rose(SINGLE_FAULT_IRQ_OUT) && $stable(fie)
      |-> $past(ARRAY_READ_IN && (cfg[0] || (ECC_SINGLE_IN && !cfg[4])));
  endproperty
  property p_dbl_hold;
    DOUBLE_FAULT_IRQ_OUT && !wr_pend |=> DOUBLE_FAULT_IRQ_OUT;
  endproperty
  property p_cmd_irq;
    CMD_DONE_IRQ_OUT == (cfg[7] && !CMD_BUSY_OUT);
  endproperty
  property p_finish;
    CMD_FINISH_IN |=> !CMD_BUSY_OUT;
  endproperty
  property p_launch;
    CMD_LAUNCH_OUT |-> s_launch;
  endproperty
  a_force_dbl: assert property (p_force_dbl)
    else $error("forced double fault gave no interrupt");
  a_force_sgl: assert property (p_force_sgl)
    else $error("forced single fault gave no interrupt");
  a_dbl_cause: assert property (p_dbl_cause)
    else $error("double fault interrupt without cause");
  a_sgl_cause: assert property (p_sgl_cause)
    else $error("single fault interrupt without cause");
  a_dbl_hold: assert property (p_dbl_hold)
    else $error("double fault interrupt dropped without write");
  a_cmd_irq: assert property (p_cmd_irq)
    else $error("command done interrupt wrong");
  a_finish: assert property (p_finish)
    else $error("busy after command finish");
  a_launch: assert property (p_launch)
    else $error("launch pulse wrong");
endmodule // fefi_properties

bind fefi_top fefi_properties i_fefi_properties (.CLK_IN, .RST_IN, .HSEL_IN, .HADDR_IN,
  .HTRANS_IN, .HWRITE_IN, .HREADY_IN, .HWDATA_IN, .ARRAY_READ_IN, .ECC_SINGLE_IN,
  .ECC_DOUBLE_IN, .CMD_FINISH_IN, .CMD_LAUNCH_OUT, .CMD_BUSY_OUT, .CMD_DONE_IRQ_OUT,
  .DOUBLE_FAULT_IRQ_OUT, .SINGLE_FAULT_IRQ_OUT);

//--- sim/test_flash_ecc_fault_irq_config.sv
`timescale 1ns/1ps
// random and corner checks of the flash fault and interrupt config block
module test_flash_ecc_fault_irq_config;
  logic CLK_IN = 1'b0;
  logic RST_IN = 1'b1;
  logic HSEL_IN = 1'b0;
  logic [31:0] HADDR_IN = 32'h0;
  logic [1:0] HTRANS_IN = 2'h0;
  logic HWRITE_IN = 1'b0;
  logic [31:0] HWDATA_IN = 32'h0;
  logic [4:0] ev_in = 5'h0;
  logic [31:0] HRDATA_OUT;
  logic [1:0] HRESP_OUT;
  logic HREADYOUT_OUT, CMD_LAUNCH_OUT, CMD_BUSY_OUT, IRQ_OUT;
  logic CMD_DONE_IRQ_OUT, DOUBLE_FAULT_IRQ_OUT, SINGLE_FAULT_IRQ_OUT;
  int n_errors = 0;
  int n_compared = 0;
  int n_launch = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic [7:0] cfg, fie, evn;
  logic [1:0] ef;

  fefi_top i_fefi_top (.CLK_IN, .RST_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN, .HWRITE_IN,
    .HSIZE_IN(3'h2), .HREADY_IN(HREADYOUT_OUT), .HWDATA_IN, .HRDATA_OUT, .HREADYOUT_OUT,
    .HRESP_OUT, .ARRAY_READ_IN(ev_in[4]), .ECC_SINGLE_IN(ev_in[3]), .ECC_DOUBLE_IN(ev_in[2]),
    .CMD_FINISH_IN(ev_in[1]), .CMD_VIOLATION_IN(ev_in[0]), .CMD_LAUNCH_OUT, .CMD_BUSY_OUT,
    .CMD_DONE_IRQ_OUT, .DOUBLE_FAULT_IRQ_OUT, .SINGLE_FAULT_IRQ_OUT, .IRQ_OUT);

  // free-running 250 MHz clock
  initial begin
    forever #2 CLK_IN = ~CLK_IN;
  end

  // cycle ceiling cuts a hang; launch pulses are counted here
  always @(posedge CLK_IN) begin
    cycles <= cycles + 1;
    if (CMD_LAUNCH_OUT === 1'b1) n_launch <= n_launch + 1;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one single transfer; waits on ready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL_IN <= 1'b1;
    HTRANS_IN <= fefi_pkg::HTRANS_NONSEQ;
    HADDR_IN <= {24'h0, a};
    HWRITE_IN <= w;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    HSEL_IN <= 1'b0;
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= wd;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    rv = HRDATA_OUT;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rv, exp, what);
    chk({30'h0, HRESP_OUT}, {30'h0, fefi_pkg::HRESP_OKAY}, "bus response");
  endtask

  // one cycle of flash events: read, single, double, finish, violation
  task automatic ev(input logic [4:0] e);
    ev_in <= e;
    @(posedge CLK_IN);
    ev_in <= 5'h0;
    @(posedge CLK_IN);
  endtask

  // fault flags expected after one array read
  function automatic logic [1:0] fexp(input logic [7:0] c, input logic si, input logic du);
    fexp = {du | c[1], c[0] | (si & ~c[4])};
  endfunction

  initial begin
    rv = $urandom(32'hb91d);
    repeat (10) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    rchk(fefi_pkg::OFS_FLASH_CONFIG, 32'h0, "cfg reset");
    rchk(fefi_pkg::OFS_FAULT_IRQ_ENABLE, 32'h0, "enable reset");
    rchk(fefi_pkg::OFS_FLASH_STATUS, 32'h80, "status reset");
    rchk(8'h1c, 32'h0, "unmapped read");
    bus(1'b1, fefi_pkg::OFS_FLASH_CONFIG, 32'hffffffff);
    rchk(fefi_pkg::OFS_FLASH_CONFIG, 32'h93, "cfg mask");
    // random settings and faults, force bits kept across reads
    repeat (40) begin
      bus(1'b1, fefi_pkg::OFS_FLASH_CONFIG, $urandom);
      cfg = HWDATA_IN[7:0] & 8'h93;
      bus(1'b1, fefi_pkg::OFS_FAULT_IRQ_ENABLE, $urandom);
      fie = HWDATA_IN[7:0] & 8'h03;
      bus(1'b1, fefi_pkg::OFS_EVT_ENABLE, $urandom);
      evn = HWDATA_IN[7:0] & 8'h07;
      bus(1'b1, fefi_pkg::OFS_FAULT_STATUS, 32'h3);
      bus(1'b1, fefi_pkg::OFS_EVT_CLEAR, 32'h7);
      rv = $urandom;
      ef = fexp(cfg, rv[1], rv[0]);
      ev({1'b1, rv[1:0], 2'b00});
      rchk(fefi_pkg::OFS_FAULT_STATUS, {30'h0, ef}, "fault flags");
      chk({31'h0, SINGLE_FAULT_IRQ_OUT}, {31'h0, ef[0] & fie[0]}, "single irq");
      chk({31'h0, DOUBLE_FAULT_IRQ_OUT}, {31'h0, ef[1] & fie[1]}, "double irq");
      chk({31'h0, IRQ_OUT}, {31'h0, |({1'b0, ef} & evn[2:0])}, "event irq");
      chk({31'h0, CMD_DONE_IRQ_OUT}, {31'h0, cfg[7]}, "cmd irq idle");
      rchk(fefi_pkg::OFS_FLASH_CONFIG, {24'h0, cfg}, "force kept");
      rchk(fefi_pkg::OFS_FAULT_IRQ_ENABLE, {24'h0, fie}, "enable rw");
      bus(1'b1, fefi_pkg::OFS_FAULT_STATUS, 32'h0);
      rchk(fefi_pkg::OFS_FAULT_STATUS, {30'h0, ef}, "zero write");
    end
    // command launch, refused relaunch, read while busy, finish
    bus(1'b1, fefi_pkg::OFS_FLASH_CONFIG, 32'h80);
    bus(1'b1, fefi_pkg::OFS_FAULT_IRQ_ENABLE, 32'h3);
    bus(1'b1, fefi_pkg::OFS_FAULT_STATUS, 32'h3);
    bus(1'b1, fefi_pkg::OFS_EVT_CLEAR, 32'h7);
    bus(1'b1, fefi_pkg::OFS_EVT_ENABLE, 32'h4);
    bus(1'b1, fefi_pkg::OFS_FLASH_STATUS, 32'h80);
    rchk(fefi_pkg::OFS_FLASH_STATUS, 32'h08, "busy status");
    chk({31'h0, CMD_BUSY_OUT}, 32'h1, "busy pin");
    chk({31'h0, CMD_DONE_IRQ_OUT}, 32'h0, "cmd irq busy");
    chk(n_launch, 32'h1, "launch count");
    bus(1'b1, fefi_pkg::OFS_FLASH_STATUS, 32'h80);
    ev(5'h10);
    rchk(fefi_pkg::OFS_FAULT_STATUS, 32'h2, "busy read");
    chk({31'h0, DOUBLE_FAULT_IRQ_OUT}, 32'h1, "busy read irq");
    ev(5'h02);
    chk({31'h0, CMD_DONE_IRQ_OUT}, 32'h1, "cmd irq done");
    chk({31'h0, IRQ_OUT}, 32'h1, "event irq done");
    chk(n_launch, 32'h1, "relaunch refused");
    rchk(fefi_pkg::OFS_EVT_STATUS, 32'h6, "events");
    bus(1'b1, fefi_pkg::OFS_EVT_CLEAR, 32'h4);
    rchk(fefi_pkg::OFS_EVT_STATUS, 32'h2, "event clear");
    chk({31'h0, IRQ_OUT}, 32'h0, "event irq cleared");
    bus(1'b1, fefi_pkg::OFS_FLASH_STATUS, 32'h80);
    ev(5'h01);
    rchk(fefi_pkg::OFS_FLASH_STATUS, 32'h80, "violation ends");
    chk({31'h0, CMD_BUSY_OUT}, 32'h0, "idle pin");
    chk(n_launch, 32'h2, "second launch");
    give_verdict();
  end
endmodule // test_flash_ecc_fault_irq_config
